// file: verilog/gcs_pkg.sv
// shared constants, types and register map of the gated count snapshot logger
package gcs_pkg;

	// snapshot memory geometry
	localparam int              REC_DEPTH = 10000;           // records 0 .. 9999
	localparam int              REC_AW    = 14;              // record index width
	localparam int              DATA_W    = 32;              // bus and record width
	localparam int              ADDR_W    = 8;               // bus byte address width

	// register byte offsets
	localparam logic [7:0]      OFS_CTRL  = 8'h00;           // run, pacing, value mode
	localparam logic [7:0]      OFS_CMD   = 8'h04;           // one-shot clear commands
	localparam logic [7:0]      OFS_PTR   = 8'h08;           // current record address
	localparam logic [7:0]      OFS_STOP  = 8'h0C;           // end record address
	localparam logic [7:0]      OFS_TPER  = 8'h10;           // internal pacing period, cycles
	localparam logic [7:0]      OFS_STAT  = 8'h14;           // live state
	localparam logic [7:0]      OFS_HWREV = 8'h18;           // hardware revision
	localparam logic [7:0]      OFS_MADDR = 8'h1C;           // readback record index
	localparam logic [7:0]      OFS_MDATA = 8'h20;           // readback record value

	// control field positions
	localparam int              CTRL_RUN  = 0;               // count begin / logging enable
	localparam int              CTRL_PACE = 1;               // two-bit pacing source, lsb
	localparam int              CTRL_DIFF = 3;               // 1: increments, 0: raw values
	localparam int              CMD_CLR_PTR = 0;             // clear record pointer
	localparam int              CMD_CLR_ALL = 1;             // clear pointer and memory
	localparam int              STAT_RUN  = 0;               // logging active
	localparam int              STAT_ERASE = 1;              // memory erase under way
	localparam int              STAT_COUNT = 2;              // counter is counting
	localparam int              STAT_ARMED = 3;              // edge mode has seen its opening edge

	// internal pacing default: one millisecond at 50 MHz
	localparam int              CLK_MHZ       = 50;
	localparam int              TPER_US       = 1000;
	localparam logic [31:0]     TPER_CYC_DEF  = 32'(TPER_US * CLK_MHZ);

	// bus answers
	localparam logic [1:0]      RESP_OKAY   = 2'h0;
	localparam logic [1:0]      RESP_SLVERR = 2'h2;

	// pacing sources
	typedef enum logic [1:0] {PACE_LEVEL, PACE_EDGE, PACE_TIMER, PACE_SPARE} gcs_pace_e;

	// logger states
	typedef enum logic [1:0] {LOG_IDLE, LOG_RUN, LOG_ERASE} gcs_log_e;

	// one write into the snapshot memory
	typedef struct packed {
		logic              en;
		logic [REC_AW-1:0] addr;
		logic [DATA_W-1:0] data;
	} gcs_mem_wr_s;

endpackage

// file: verilog/gcs_snap_mem.sv
// snapshot record memory: one write port, one registered read port
module gcs_snap_mem #(
	parameter int DEPTH = gcs_pkg::REC_DEPTH,
	parameter int AW    = gcs_pkg::REC_AW,
	parameter int DW    = gcs_pkg::DATA_W
) (
	// clock
	input  wire logic          aclk,
	// write side
	input  wire gcs_pkg::gcs_mem_wr_s wr,
	// read side
	input  wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0]      rd_data
);

	logic [DW-1:0] mem [DEPTH];      // record storage, no reset so it maps to block ram

	generate
		if (DEPTH > (1 << AW))
		begin : g_bad
			$error("gcs_snap_mem: depth exceeds address width");
		end
	endgenerate

	// a store simply overwrites whatever the record held
	always_ff @(posedge aclk)
	begin
		if (wr.en)
			mem[wr.addr] <= wr.data;
		rd_data <= mem[rd_addr];     // read data always from a register
	end

endmodule // gcs_snap_mem

// file: verilog/gcs_logger.sv
// gated count snapshot logger with AXI4-Lite register slave
module gcs_logger #(
	parameter int          DEPTH  = gcs_pkg::REC_DEPTH,
	parameter logic [31:0] HW_REV = 32'h0000_0004   // arbitrary revision value
) (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// pins
	input  wire logic                        gate_pin,
	input  wire logic                        count_pin,
	// axi write address and data
	input  wire logic [gcs_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [gcs_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// axi write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi read
	input  wire logic [gcs_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [gcs_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);

	localparam int              AW   = gcs_pkg::REC_AW;
	localparam int              DW   = gcs_pkg::DATA_W;
	localparam logic [AW-1:0]   LAST = AW'(DEPTH - 1);      // highest record index
	localparam logic [AW-1:0]   ONE  = AW'(1);

	generate
		if (DEPTH < 2 || DEPTH > (1 << AW))
		begin : g_bad
			$error("gcs_logger: depth out of range");
		end
	endgenerate

	// pin synchronisers: stage a feeds stage b only
	logic [1:0] gate_a_r, gate_b_r, gate_d_r;   // [0] gate, [1] count pulse
	logic       gate_s, cnt_s, gate_old, cnt_old;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gate_a_r <= 2'h0;
			gate_b_r <= 2'h0;
			gate_d_r <= 2'h0;
		end
		else
		begin
			gate_a_r <= {count_pin, gate_pin};
			gate_b_r <= gate_a_r;
			gate_d_r <= gate_b_r;                // delayed copy for edge detection
		end
	end

	assign gate_s   = gate_b_r[0];
	assign cnt_s    = gate_b_r[1];
	assign gate_old = gate_d_r[0];
	assign cnt_old  = gate_d_r[1];

	// state registers and next values
	gcs_pkg::gcs_log_e     st_r, st_nxt;           // logger state
	logic                  run_r, run_nxt;          // software run request
	gcs_pkg::gcs_pace_e    pace_r, pace_nxt;        // pacing source
	logic                  diff_r, diff_nxt;        // increment mode
	logic [AW-1:0]         ptr_r, ptr_nxt;          // current record address
	logic [AW-1:0]         stop_r, stop_nxt;        // end record address
	logic [AW-1:0]         madr_r, madr_nxt;        // readback index
	logic [AW-1:0]         eadr_r, eadr_nxt;        // erase walk index
	logic [31:0]           tper_r, tper_nxt;        // timer period
	logic [31:0]           tcnt_r, tcnt_nxt;        // timer position
	logic                  armed_r, armed_nxt;      // edge mode opened
	logic [DW-1:0]         cnt_r, cnt_nxt;          // the counter itself
	logic [DW-1:0]         prev_r, prev_nxt;        // value at previous capture
	gcs_pkg::gcs_mem_wr_s  mw_r, mw_nxt;            // pending memory write
	logic                  aw_full_r, aw_full_nxt;  // address latched
	logic                  w_full_r, w_full_nxt;    // data latched
	logic [7:0]            awa_r, awa_nxt;          // latched write address
	logic [DW-1:0]         wd_r, wd_nxt;            // latched write data
	logic                  awrdy_r, awrdy_nxt;
	logic                  wrdy_r, wrdy_nxt;
	logic                  bvld_r, bvld_nxt;
	logic [1:0]            bresp_r, bresp_nxt;
	logic                  arrdy_r, arrdy_nxt;
	logic                  rvld_r, rvld_nxt;
	logic [1:0]            rresp_r, rresp_nxt;
	logic [DW-1:0]         rdat_r, rdat_nxt;
	logic [DW-1:0]         mem_rdata;               // registered memory read

	// combinational helpers
	logic           counting, store, do_wr, gate_fall, gate_rise, tick, start;
	logic [AW-1:0]  wval;

	gcs_snap_mem #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) u_mem (
		.aclk    (aclk),
		.wr      (mw_r),
		.rd_addr (madr_r),
		.rd_data (mem_rdata)
	);

	// next-state logic for the logger and the bus slave
	always_comb
	begin
		st_nxt    = st_r;
		run_nxt   = run_r;
		pace_nxt  = pace_r;
		diff_nxt  = diff_r;
		ptr_nxt   = ptr_r;
		stop_nxt  = stop_r;
		madr_nxt  = madr_r;
		eadr_nxt  = eadr_r;
		tper_nxt  = tper_r;
		tcnt_nxt  = tcnt_r;
		armed_nxt = armed_r;
		cnt_nxt   = cnt_r;
		prev_nxt  = prev_r;
		mw_nxt    = '0;
		aw_full_nxt = aw_full_r;
		w_full_nxt  = w_full_r;
		awa_nxt   = awa_r;
		wd_nxt    = wd_r;
		bvld_nxt  = bvld_r;
		bresp_nxt = bresp_r;
		rvld_nxt  = rvld_r;
		rresp_nxt = rresp_r;
		rdat_nxt  = rdat_r;
		start     = 1'b0;
		wval      = wd_r[AW-1:0];

		gate_fall = gate_old & ~gate_s;
		gate_rise = ~gate_old & gate_s;
		tick      = (st_r == gcs_pkg::LOG_RUN) && (tcnt_r >= tper_r - 32'h1);

		// counting window per pacing source
		case (pace_r)
			gcs_pkg::PACE_LEVEL: counting = gate_s;
			gcs_pkg::PACE_EDGE:  counting = armed_r;
			gcs_pkg::PACE_TIMER: counting = gate_s;               // gate still gates counting
			default:             counting = 1'b0;
		endcase
		counting = counting && (st_r == gcs_pkg::LOG_RUN);

		// capture moment per pacing source
		case (pace_r)
			gcs_pkg::PACE_LEVEL: store = gate_fall;
			gcs_pkg::PACE_EDGE:  store = armed_r & gate_rise;
			gcs_pkg::PACE_TIMER: store = tick;
			default:             store = 1'b0;
		endcase
		store = store && (st_r == gcs_pkg::LOG_RUN);

		// counter; the stored value is the count before this cycle's pulse
		if (counting && cnt_s && !cnt_old)
			cnt_nxt = cnt_r + 32'h1;

		// internal pacing timer
		if (st_r == gcs_pkg::LOG_RUN)
			tcnt_nxt = tick ? 32'h0 : tcnt_r + 32'h1;

		// edge mode opens at the first falling edge after start
		if (st_r == gcs_pkg::LOG_RUN && pace_r == gcs_pkg::PACE_EDGE && gate_fall)
			armed_nxt = 1'b1;

		// snapshot store, overwriting the record in place
		if (store)
		begin
			mw_nxt.en   = 1'b1;
			mw_nxt.addr = ptr_r;
			mw_nxt.data = diff_r ? cnt_r - prev_r : cnt_r;
			prev_nxt    = cnt_r;
			ptr_nxt     = (ptr_r == LAST) ? ptr_r : ptr_r + ONE;
			if (ptr_r == LAST)
				run_nxt = 1'b0;                                   // memory end also halts
		end

		// auto halt on reaching the end record
		if (st_r == gcs_pkg::LOG_RUN && (ptr_nxt == stop_r || !run_nxt))
		begin
			st_nxt  = gcs_pkg::LOG_IDLE;
			run_nxt = 1'b0;
		end

		// erase walk: one record per cycle, bus stalled meanwhile
		if (st_r == gcs_pkg::LOG_ERASE)
		begin
			mw_nxt.en   = 1'b1;
			mw_nxt.addr = eadr_r;
			mw_nxt.data = '0;
			eadr_nxt    = eadr_r + ONE;
			if (eadr_r == LAST)
				st_nxt = gcs_pkg::LOG_IDLE;
		end

		// bus write channels, taken in either order
		if (s_axi_awvalid && awrdy_r)
		begin
			aw_full_nxt = 1'b1;
			awa_nxt     = s_axi_awaddr;
		end
		if (s_axi_wvalid && wrdy_r)
		begin
			w_full_nxt = 1'b1;
			wd_nxt     = s_axi_wdata;
		end
		if (s_axi_bready && bvld_r)
			bvld_nxt = 1'b0;

		// register write once both halves are held
		do_wr = aw_full_r && w_full_r && !bvld_r;
		if (do_wr)
		begin
			aw_full_nxt = 1'b0;
			w_full_nxt  = 1'b0;
			bvld_nxt    = 1'b1;
			bresp_nxt   = gcs_pkg::RESP_OKAY;
			case ({awa_r[7:2], 2'h0})
				gcs_pkg::OFS_CTRL:
				begin
					pace_nxt = gcs_pkg::gcs_pace_e'(wd_r[gcs_pkg::CTRL_PACE +: 2]);
					diff_nxt = wd_r[gcs_pkg::CTRL_DIFF];
					run_nxt  = wd_r[gcs_pkg::CTRL_RUN];
					if (!wd_r[gcs_pkg::CTRL_RUN])
						st_nxt = gcs_pkg::LOG_IDLE;               // stop at once
					else if (!run_r)
						start = 1'b1;                             // count begin
				end
				gcs_pkg::OFS_CMD:
				begin
					if (wd_r[gcs_pkg::CMD_CLR_PTR] || wd_r[gcs_pkg::CMD_CLR_ALL])
					begin
						ptr_nxt = '0;
						st_nxt  = gcs_pkg::LOG_IDLE;
						run_nxt = 1'b0;
					end
					if (wd_r[gcs_pkg::CMD_CLR_ALL])
					begin
						st_nxt   = gcs_pkg::LOG_ERASE;
						eadr_nxt = '0;
					end
				end
				gcs_pkg::OFS_PTR:
					if (wd_r[DW-1:AW] == '0 && wval <= LAST)
						ptr_nxt = wval;
					else
						bresp_nxt = gcs_pkg::RESP_SLVERR;
				gcs_pkg::OFS_STOP:
					if (wd_r[DW-1:AW] == '0 && wval <= LAST)
						stop_nxt = wval;
					else
						bresp_nxt = gcs_pkg::RESP_SLVERR;
				gcs_pkg::OFS_TPER:
					if (wd_r != '0)
						tper_nxt = wd_r;
					else
						bresp_nxt = gcs_pkg::RESP_SLVERR;
				gcs_pkg::OFS_MADDR:
					if (wd_r[DW-1:AW] == '0 && wval <= LAST)
						madr_nxt = wval;
					else
						bresp_nxt = gcs_pkg::RESP_SLVERR;
				gcs_pkg::OFS_STAT, gcs_pkg::OFS_HWREV, gcs_pkg::OFS_MDATA:
					bresp_nxt = gcs_pkg::RESP_OKAY;               // read-only, write ignored
				default:
					bresp_nxt = gcs_pkg::RESP_SLVERR;
			endcase
		end

		// a start clears the counter and the increment base
		if (start)
		begin
			st_nxt    = gcs_pkg::LOG_RUN;
			cnt_nxt   = '0;
			prev_nxt  = '0;
			tcnt_nxt  = '0;
			armed_nxt = 1'b0;
			if (ptr_r == stop_r)
				st_nxt = gcs_pkg::LOG_IDLE;                       // already at the end
		end
		if (st_nxt != gcs_pkg::LOG_RUN)
			armed_nxt = armed_nxt & (st_nxt == gcs_pkg::LOG_RUN);

		// bus read, answered one cycle after the address is taken
		if (s_axi_rready && rvld_r)
			rvld_nxt = 1'b0;
		if (s_axi_arvalid && arrdy_r)
		begin
			rvld_nxt  = 1'b1;
			rresp_nxt = gcs_pkg::RESP_OKAY;
			rdat_nxt  = '0;
			case ({s_axi_araddr[7:2], 2'h0})
				gcs_pkg::OFS_CTRL:
				begin
					rdat_nxt[gcs_pkg::CTRL_RUN]       = run_r;
					rdat_nxt[gcs_pkg::CTRL_PACE +: 2] = pace_r;
					rdat_nxt[gcs_pkg::CTRL_DIFF]      = diff_r;
				end
				gcs_pkg::OFS_CMD:   rdat_nxt = '0;
				gcs_pkg::OFS_PTR:   rdat_nxt[AW-1:0] = ptr_r;
				gcs_pkg::OFS_STOP:  rdat_nxt[AW-1:0] = stop_r;
				gcs_pkg::OFS_TPER:  rdat_nxt = tper_r;
				gcs_pkg::OFS_STAT:
				begin
					rdat_nxt[gcs_pkg::STAT_RUN]   = (st_r == gcs_pkg::LOG_RUN);
					rdat_nxt[gcs_pkg::STAT_ERASE] = (st_r == gcs_pkg::LOG_ERASE);
					rdat_nxt[gcs_pkg::STAT_COUNT] = counting;
					rdat_nxt[gcs_pkg::STAT_ARMED] = armed_r;
				end
				gcs_pkg::OFS_HWREV: rdat_nxt = HW_REV;
				gcs_pkg::OFS_MADDR: rdat_nxt[AW-1:0] = madr_r;
				gcs_pkg::OFS_MDATA: rdat_nxt = mem_rdata;
				default:            rresp_nxt = gcs_pkg::RESP_SLVERR;
			endcase
		end

		// ready terms: no new access is taken while the erase runs
		awrdy_nxt = !aw_full_nxt && st_nxt != gcs_pkg::LOG_ERASE;
		wrdy_nxt  = !w_full_nxt && st_nxt != gcs_pkg::LOG_ERASE;
		arrdy_nxt = !rvld_nxt && st_nxt != gcs_pkg::LOG_ERASE;
	end

	// register stage; raw mode and full memory range after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r    <= gcs_pkg::LOG_IDLE;
			run_r   <= 1'b0;
			pace_r  <= gcs_pkg::PACE_LEVEL;
			diff_r  <= 1'b0;
			ptr_r   <= '0;
			stop_r  <= LAST;
			madr_r  <= '0;
			eadr_r  <= '0;
			tper_r  <= gcs_pkg::TPER_CYC_DEF;
			tcnt_r  <= '0;
			armed_r <= 1'b0;
			cnt_r   <= '0;
			prev_r  <= '0;
			mw_r    <= '0;
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awa_r   <= '0;
			wd_r    <= '0;
			awrdy_r <= 1'b0;
			wrdy_r  <= 1'b0;
			bvld_r  <= 1'b0;
			bresp_r <= gcs_pkg::RESP_OKAY;
			arrdy_r <= 1'b0;
			rvld_r  <= 1'b0;
			rresp_r <= gcs_pkg::RESP_OKAY;
			rdat_r  <= '0;
		end
		else
		begin
			st_r    <= st_nxt;
			run_r   <= run_nxt;
			pace_r  <= pace_nxt;
			diff_r  <= diff_nxt;
			ptr_r   <= ptr_nxt;
			stop_r  <= stop_nxt;
			madr_r  <= madr_nxt;
			eadr_r  <= eadr_nxt;
			tper_r  <= tper_nxt;
			tcnt_r  <= tcnt_nxt;
			armed_r <= armed_nxt;
			cnt_r   <= cnt_nxt;
			prev_r  <= prev_nxt;
			mw_r    <= mw_nxt;
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awa_r   <= awa_nxt;
			wd_r    <= wd_nxt;
			awrdy_r <= awrdy_nxt;
			wrdy_r  <= wrdy_nxt;
			bvld_r  <= bvld_nxt;
			bresp_r <= bresp_nxt;
			arrdy_r <= arrdy_nxt;
			rvld_r  <= rvld_nxt;
			rresp_r <= rresp_nxt;
			rdat_r  <= rdat_nxt;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awrdy_r;
	assign s_axi_wready  = wrdy_r;
	assign s_axi_bvalid  = bvld_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arrdy_r;
	assign s_axi_rvalid  = rvld_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdat_r;

endmodule // gcs_logger

// file: testbench/gcs_logger_assertions.sv
// bus timing checker for the snapshot logger register slave
module gcs_logger_chk (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// write channels
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read channels
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// one clock domain, so one default clock and reset for all
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high after address taken");
	w_drop_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("wready stayed high after data taken");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle after address");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer not two cycles after transfer");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write answer not held");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer not held");
	b_release_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("bvalid dropped without bready");
	r_release_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
		else $error("rvalid dropped without rready");
	resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == gcs_pkg::RESP_OKAY
		|| s_axi_bresp == gcs_pkg::RESP_SLVERR)
		else $error("illegal write response code");
endmodule // gcs_logger_chk

bind gcs_logger gcs_logger_chk u_gcs_logger_chk (
	.aclk          (aclk),
	.aresetn       (aresetn),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rresp   (s_axi_rresp),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready)
);

// file: testbench/gcs_pulse_src.sv
// external gate and count pulse source facing the logger pins
module gcs_pulse_src (
	// clock
	input wire logic       aclk,
	// commands from the bench
	input wire logic       gate_lvl,
	input wire logic [7:0] burst_n,
	input wire logic       go,
	// pins
	output logic           gate_pin,
	output logic           count_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] left_r = 10'h000; // quarter phases left in the burst
	// four cycles per pulse so each rise survives the pin synchroniser
	always_ff @(posedge aclk)
		if (go)
			left_r <= {burst_n, 2'b00};
		else if (left_r != 10'h000)
			left_r <= left_r - 10'h001;
	assign count_pin = left_r[1]; // high two cycles of every four
	assign gate_pin  = gate_lvl;
endmodule // gcs_pulse_src

// file: testbench/gcs_logger_bench.sv
// register level bench for the gated count snapshot logger
module gcs_logger_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// bench drive and design answers
	logic        aclk = 1'b0, aresetn = 1'b0, gate_lvl = 1'b0, go = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, burst_n = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, gate_pin, count_pin;
	int          error_cnt = 0, total_checks = 0, cyc = 0;

	gcs_logger u_gcs_logger (
		.aclk(aclk), .aresetn(aresetn), .gate_pin(gate_pin), .count_pin(count_pin),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready)
	);
	gcs_pulse_src u_gcs_pulse_src (.aclk(aclk), .gate_lvl(gate_lvl), .burst_n(burst_n),
		.go(go), .gate_pin(gate_pin), .count_pin(count_pin));

	// 50 MHz clock
	initial
	begin
		forever #10 aclk = ~aclk;
	end

	// verdict and end of run
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// the erase alone takes ten thousand cycles, the rest about one thousand
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: run did not finish", $time);
			close_out();
		end
	end

	// compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one write, address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = gcs_pkg::RESP_OKAY);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1)
			begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready === 1'b1)
			begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// one read, answer compared with the expected word and code
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = gcs_pkg::RESP_OKAY);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// read back one stored record
	task automatic mem(input logic [31:0] i, input logic [31:0] e);
		wr(gcs_pkg::OFS_MADDR, i);
		rd(gcs_pkg::OFS_MDATA, e);
	endtask

	// count pulses, then settle past the pin synchroniser
	task automatic pulses(input logic [7:0] n);
		@(posedge aclk);
		burst_n <= n;
		go      <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (4 * n + 8) @(posedge aclk);
	endtask

	// move the gate and let the edge reach the core
	task automatic gate(input logic v);
		@(posedge aclk);
		gate_lvl <= v;
		repeat (10) @(posedge aclk);
	endtask

	// one gate-high window with n pulses inside it
	// a store needs one cycle here, so the host minimum window scales to a few dozen cycles
	task automatic period(input logic [7:0] n);
		gate(1'b1);
		pulses(n);
		gate(1'b0);
	endtask

	// main sequence
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(gcs_pkg::OFS_CTRL, 32'h0);
		rd(gcs_pkg::OFS_STOP, 32'h270F);
		// raw values, level pacing, halt at record 3
		wr(gcs_pkg::OFS_STOP, 32'h3);
		wr(gcs_pkg::OFS_CTRL, 32'h1);
		period(5);
		period(3);
		period(4);
		period(2);
		rd(gcs_pkg::OFS_PTR, 32'h3);
		rd(gcs_pkg::OFS_CTRL, 32'h0);
		mem(0, 5);
		mem(1, 8);
		mem(2, 12);
		// increments over the old records
		wr(gcs_pkg::OFS_PTR, 32'h0);
		wr(gcs_pkg::OFS_STOP, 32'h2);
		wr(gcs_pkg::OFS_CTRL, 32'h9);
		period(2);
		period(6);
		mem(0, 2);
		mem(1, 6);
		mem(2, 12);
		// edge pacing: pulses before the opening fall are lost
		wr(gcs_pkg::OFS_STOP, 32'h1);
		wr(gcs_pkg::OFS_PTR, 32'h0);
		wr(gcs_pkg::OFS_CTRL, 32'h3);
		pulses(3);
		period(0);
		rd(gcs_pkg::OFS_STAT, 32'hD);
		pulses(4);
		gate(1'b1);
		gate(1'b0);
		rd(gcs_pkg::OFS_PTR, 32'h1);
		mem(0, 4);
		wr(gcs_pkg::OFS_CMD, 32'h1);
		rd(gcs_pkg::OFS_PTR, 32'h0);
		mem(0, 4);
		// internal timer pacing
		wr(gcs_pkg::OFS_TPER, 32'h0, gcs_pkg::RESP_SLVERR);
		rd(gcs_pkg::OFS_TPER, gcs_pkg::TPER_CYC_DEF);
		wr(gcs_pkg::OFS_TPER, 32'd200);
		wr(gcs_pkg::OFS_CTRL, 32'h5);
		repeat (300) @(posedge aclk);
		rd(gcs_pkg::OFS_PTR, 32'h1);
		rd(gcs_pkg::OFS_CTRL, 32'h4);
		mem(0, 0);
		// pointer and end record range
		wr(gcs_pkg::OFS_PTR, 32'd10000, gcs_pkg::RESP_SLVERR);
		rd(gcs_pkg::OFS_PTR, 32'h1);
		wr(gcs_pkg::OFS_PTR, 32'd9999);
		rd(gcs_pkg::OFS_PTR, 32'd9999);
		wr(gcs_pkg::OFS_STOP, 32'd10000, gcs_pkg::RESP_SLVERR);
		rd(gcs_pkg::OFS_STOP, 32'h1);
		// erase everything; the next read waits out the erase
		wr(gcs_pkg::OFS_CMD, 32'h2);
		rd(gcs_pkg::OFS_PTR, 32'h0);
		mem(1, 0);
		mem(2, 0);
		rd(gcs_pkg::OFS_MADDR, 32'h2);
		rd(gcs_pkg::OFS_STAT, 32'h0);
		wr(gcs_pkg::OFS_STAT, 32'hF);
		rd(gcs_pkg::OFS_STAT, 32'h0);
		rd(gcs_pkg::OFS_CMD, 32'h0);
		// unmapped offset
		wr(8'h40, 32'h1, gcs_pkg::RESP_SLVERR);
		rd(8'h40, 32'h0, gcs_pkg::RESP_SLVERR);
		close_out();
	end
endmodule // gcs_logger_bench
